// ==== design/rtrb_consts.svh ====
// Offsets, field positions, reset values and scale constants of the
// radio tuning register bank.
// Assumes it is included by bare name from the coefficient table, rate and bank design files.
`ifndef RTRB_CONSTS_SVH
`define RTRB_CONSTS_SVH
`define RTRB_OFS_CONV1 8'h67
`define RTRB_OFS_CONV2 8'h68
`define RTRB_OFS_GAIN1 8'h69
`define RTRB_OFS_GAIN2 8'h6a
`define RTRB_OFS_CIDX 8'h6b
`define RTRB_OFS_CVAL 8'h6c
`define RTRB_OFS_TXPOW 8'h6d
`define RTRB_OFS_RATE_HI 8'h6e
`define RTRB_OFS_RATE_LO 8'h6f
`define RTRB_OFS_MOD1 8'h70
`define RTRB_RST_CONV1 8'h1d
`define RTRB_RST_CONV2 5'h00
`define RTRB_RST_GAIN1 6'h20
`define RTRB_RST_GAIN2 8'h00
`define RTRB_RST_CIDX 3'h0
`define RTRB_RST_TXPOW 4'h8
`define RTRB_RST_RATE_HI 8'h0a
`define RTRB_RST_RATE_LO 8'h0d
`define RTRB_RST_SCALE 1'b0
`define RTRB_BIT_AGC_EN 5
`define RTRB_BIT_LNA 4
`define RTRB_BIT_SCALE 5
`define RTRB_CIDX_NONE 3'h7
`define RTRB_COEF0 6'h01
`define RTRB_COEF1 6'h03
`define RTRB_COEF2 6'h06
`define RTRB_COEF3 6'h0a
`define RTRB_COEF4 6'h0f
`define RTRB_COEF5 6'h13
`define RTRB_COEF6 6'h14
`define RTRB_REF_BASE_MV 11'h1f4
`define RTRB_REF_STEP_MV 11'h064
`define RTRB_LNA_MIN_DB 5'h05
`define RTRB_LNA_MAX_DB 5'h19
`define RTRB_PGA_STEP_DB 5'h03
`define RTRB_PGA_MAX_CODE 4'h5
`define RTRB_PGA_MAX_DB 5'h18
`define RTRB_POW_MIN_DBM 5'h08
`define RTRB_POW_STEP_DBM 5'h03
`define RTRB_RATE_MULT 26'h00003e8
`define RTRB_RATE_SHIFT_FINE 16
`define RTRB_RATE_SHIFT_COARSE 21
`define RTRB_LOW_RATE_KBPS 10'h01e
`endif

// ==== design/rtrb_pkg.sv ====
// Types shared by the radio tuning register bank modules.
// Assumes nothing beyond the constants header.
package rtrb_pkg;
    typedef logic [7:0] rtrb_byte_t;
    typedef logic [5:0] rtrb_coeff_t;
    typedef logic [2:0] rtrb_idx_t;
endpackage

// ==== design/rtrb_coeff_if.sv ====
// Link between the register bank and its coefficient table.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rtrb_coeff_if;
    import rtrb_pkg::*;
    logic wr_en;
    rtrb_idx_t wr_addr;
    rtrb_coeff_t wr_data;
    rtrb_idx_t rd_addr;
    rtrb_coeff_t rd_data;
    rtrb_idx_t tap_addr;
    rtrb_coeff_t tap_data;
    modport bank (output wr_en, wr_addr, wr_data, rd_addr, tap_addr,
                  input rd_data, tap_data);
    modport table_end (input wr_en, wr_addr, wr_data, rd_addr, tap_addr,
                       output rd_data, tap_data);
endinterface

// ==== design/rtrb_coeff_mem.sv ====
// Shaping-filter coefficient table with a software port and a tap port.
// Assumes a synchronous active-high reset that reloads the defaults.
`timescale 1ns/1ps
`include "rtrb_consts.svh"
module rtrb_coeff_mem
    import rtrb_pkg::*;
#(
    parameter int DEPTH = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Table port
    rtrb_coeff_if.table_end cif
);
    rtrb_coeff_t mem_q [DEPTH];
    rtrb_coeff_t rd_q;
    rtrb_coeff_t tap_q;

    function automatic rtrb_coeff_t dflt(input int i);
        case (i)
            0: dflt = `RTRB_COEF0;
            1: dflt = `RTRB_COEF1;
            2: dflt = `RTRB_COEF2;
            3: dflt = `RTRB_COEF3;
            4: dflt = `RTRB_COEF4;
            5: dflt = `RTRB_COEF5;
            6: dflt = `RTRB_COEF6;
            default: dflt = 6'h00;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (srst) begin
                mem_q[i] <= dflt(i);
            end else if (cif.wr_en && int'(cif.wr_addr) == i) begin
                mem_q[i] <= cif.wr_data;
            end
        end
    end

    // A write in flight is forwarded so a read right after it sees it.
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_q <= 6'h00;
        end else if (int'(cif.rd_addr) >= DEPTH) begin
            rd_q <= 6'h00;
        end else if (cif.wr_en && cif.wr_addr == cif.rd_addr) begin
            rd_q <= cif.wr_data;
        end else begin
            rd_q <= mem_q[cif.rd_addr];
        end
    end

    always_ff @(posedge clk) begin
        if (srst || int'(cif.tap_addr) >= DEPTH) begin
            tap_q <= 6'h00;
        end else begin
            tap_q <= mem_q[cif.tap_addr];
        end
    end

    assign cif.rd_data = rd_q;
    assign cif.tap_data = tap_q;
endmodule

// ==== design/rtrb_rate_calc.sv ====
// Turns the transmit rate word and scale bit into whole kbps.
// Assumes its inputs come from registers on the same clock.
`timescale 1ns/1ps
`include "rtrb_consts.svh"
module rtrb_rate_calc (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Rate setting
    input wire logic [15:0] rate_word,
    input wire logic rate_scale,
    // Result
    output logic [9:0] rate_kbps,
    output logic rate_low
);
    logic [25:0] prod;
    logic [25:0] quot;
    assign prod = {10'h000, rate_word} * `RTRB_RATE_MULT;
    assign quot = rate_scale ? (prod >> `RTRB_RATE_SHIFT_COARSE)
                             : (prod >> `RTRB_RATE_SHIFT_FINE);

    always_ff @(posedge clk) begin
        if (srst) begin
            rate_kbps <= 10'h000;
            rate_low <= 1'b0;
        end else begin
            rate_kbps <= quot[9:0];
            rate_low <= quot[9:0] < `RTRB_LOW_RATE_KBPS;
        end
    end
endmodule

// ==== design/rtrb_bank.sv ====
// Byte-wide tuning, gain, shaping, power and rate registers of a radio.
// Assumes a host on the same clock with one-cycle read and write strobes;
// the gain loop and preamble detector also run on this clock.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "rtrb_consts.svh"

////////////////////////////////////////////////////////////////////////
// What this block does
// - Converter tuning: reset, enables, calibration override.
// - Reference level code maps 0.5 V upward.
// - Second tuning: common-mode, open loop, reserved.
// - Gain bits show loop result when automatic.
// - Front-end gain bit: 5 dB or 25 dB.
// - Amplifier gain code in 3 dB steps.
// - Gain loop may ignore preamble detection.
// - Slow-rise bit slows only gain increases.
// - Compensation value smooths strength on steps.
// - Low bits adjust window comparator reference.
// - Index selects one of seven coefficients.
// - Coefficients default to a 0.5 product.
// - Value field reads and writes indexed entry.
// - Power bits choose +8 to +17 dBm.
// - Extra power bit; upper bits reserved.
// - Upper rate byte, reset 0x0a.
// - Rate equals 1000 times word over shift.
// - Lower rate byte resets to 0x0d.
module rtrb_bank
    import rtrb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Gain loop
    input wire logic [4:0] agc_gain_result,
    input wire logic preamble_detected,
    output logic agc_enable,
    output logic agc_run,
    output logic agc_slow_rise,
    output logic [3:0] lna_comp,
    output logic [1:0] window_ref_adj,
    output logic lna_gain_max,
    output logic [4:0] lna_gain_db,
    output logic [3:0] amp_gain_code,
    output logic [4:0] amp_gain_db,
    // Converter controls
    output logic adc_reset,
    output logic ref_dac_enable,
    output logic adc_enable,
    output logic adc_tune_override,
    output logic [3:0] adc_tune_value,
    output logic vcm_enable,
    output logic adc_open_loop,
    output logic [10:0] adc_ref_mv,
    // Shaping filter taps
    input wire logic [2:0] filter_tap_addr,
    output logic [5:0] filter_tap_coeff,
    // Transmit power and rate
    output logic [1:0] tx_power_level,
    output logic tx_power_extra,
    output logic [4:0] tx_power_dbm,
    output logic [15:0] tx_rate_word,
    output logic tx_rate_scale,
    output logic [9:0] tx_rate_kbps,
    output logic tx_rate_low_unscaled
);
    rtrb_byte_t conv1_q;
    logic [4:0] conv2_q;
    logic [5:0] gain1_q;
    rtrb_byte_t gain2_q;
    rtrb_idx_t cidx_q;
    rtrb_idx_t cidx_d;
    logic [3:0] txpow_q;
    rtrb_byte_t rate_hi_q;
    rtrb_byte_t rate_lo_q;
    logic scale_q;
    rtrb_byte_t rdata_q;
    rtrb_byte_t rdata_d;
    logic [4:0] gain_eff;
    logic [4:0] lna_db_q;
    logic [4:0] amp_db_q;
    logic [3:0] amp_code_q;
    logic lna_max_q;
    logic agc_run_q;
    logic [10:0] ref_mv_q;
    logic [4:0] pow_dbm_q;
    logic [9:0] rate_kbps;
    logic rate_low;
    logic low_unscaled_q;

    rtrb_coeff_if cif ();

    ////////////////////////////////////////////////////////////////////
    // Write decode
    logic wr_conv1, wr_conv2, wr_gain1, wr_gain2, wr_cidx, wr_cval;
    logic wr_txpow, wr_rate_hi, wr_rate_lo, wr_mod1;

    assign wr_conv1 = reg_wr && reg_addr == `RTRB_OFS_CONV1;
    assign wr_conv2 = reg_wr && reg_addr == `RTRB_OFS_CONV2;
    assign wr_gain1 = reg_wr && reg_addr == `RTRB_OFS_GAIN1;
    assign wr_gain2 = reg_wr && reg_addr == `RTRB_OFS_GAIN2;
    assign wr_cidx = reg_wr && reg_addr == `RTRB_OFS_CIDX;
    assign wr_cval = reg_wr && reg_addr == `RTRB_OFS_CVAL;
    assign wr_txpow = reg_wr && reg_addr == `RTRB_OFS_TXPOW;
    assign wr_rate_hi = reg_wr && reg_addr == `RTRB_OFS_RATE_HI;
    assign wr_rate_lo = reg_wr && reg_addr == `RTRB_OFS_RATE_LO;
    assign wr_mod1 = reg_wr && reg_addr == `RTRB_OFS_MOD1;

    ////////////////////////////////////////////////////////////////////
    // Converter tuning
    always_ff @(posedge clk) begin
        if (srst) begin
            conv1_q <= `RTRB_RST_CONV1;
        end else if (wr_conv1) begin
            conv1_q <= reg_wdata;
        end
    end

    // Only the five defined bits are stored, so the top three stay zero.
    always_ff @(posedge clk) begin
        if (srst) begin
            conv2_q <= `RTRB_RST_CONV2;
        end else if (wr_conv2) begin
            conv2_q <= reg_wdata[4:0];
        end
    end

    // The reference code is linear, 100 mV a step from 0.5 V.
    always_ff @(posedge clk) begin
        if (srst) begin
            ref_mv_q <= `RTRB_REF_BASE_MV;
        end else begin
            ref_mv_q <= `RTRB_REF_BASE_MV
                + {8'h00, conv2_q[2:0]} * `RTRB_REF_STEP_MV;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Gain control
    always_ff @(posedge clk) begin
        if (srst) begin
            gain1_q <= `RTRB_RST_GAIN1;
        end else if (wr_gain1) begin
            gain1_q <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gain2_q <= `RTRB_RST_GAIN2;
        end else if (wr_gain2) begin
            gain2_q <= reg_wdata;
        end
    end

    // Manual values are kept while the loop runs so that turning the loop
    // off returns the gain to what software last chose.
    assign gain_eff = gain1_q[`RTRB_BIT_AGC_EN] ? agc_gain_result
                                                : gain1_q[4:0];

    always_ff @(posedge clk) begin
        if (srst) begin
            lna_max_q <= 1'b0;
            lna_db_q <= `RTRB_LNA_MIN_DB;
        end else begin
            lna_max_q <= gain_eff[`RTRB_BIT_LNA];
            lna_db_q <= gain_eff[`RTRB_BIT_LNA] ? `RTRB_LNA_MAX_DB
                                                : `RTRB_LNA_MIN_DB;
        end
    end

    // Codes past the top step clamp to the largest gain.
    always_ff @(posedge clk) begin
        if (srst) begin
            amp_code_q <= 4'h0;
            amp_db_q <= 5'h00;
        end else begin
            amp_code_q <= gain_eff[3:0];
            if (gain_eff[3:0] > `RTRB_PGA_MAX_CODE) begin
                amp_db_q <= `RTRB_PGA_MAX_DB;
            end else begin
                amp_db_q <= {1'b0, gain_eff[3:0]} * `RTRB_PGA_STEP_DB;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            agc_run_q <= 1'b0;
        end else begin
            agc_run_q <= gain1_q[`RTRB_BIT_AGC_EN]
                && (gain2_q[7] || preamble_detected);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shaping coefficients
    always_comb begin
        cidx_d = cidx_q;
        if (wr_cidx) begin
            cidx_d = reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cidx_q <= `RTRB_RST_CIDX;
        end else begin
            cidx_q <= cidx_d;
        end
    end

    // Index seven names no entry, so a value write there is dropped.
    assign cif.wr_en = wr_cval && cidx_q != `RTRB_CIDX_NONE;
    assign cif.wr_addr = cidx_q;
    assign cif.wr_data = reg_wdata[5:0];
    assign cif.rd_addr = cidx_d;
    assign cif.tap_addr = filter_tap_addr;

    rtrb_coeff_mem #(
        .DEPTH(7)
    ) u_coeff (
        .clk(clk),
        .srst(srst),
        .cif(cif)
    );

    ////////////////////////////////////////////////////////////////////
    // Transmit power and rate
    always_ff @(posedge clk) begin
        if (srst) begin
            txpow_q <= `RTRB_RST_TXPOW;
        end else if (wr_txpow) begin
            txpow_q <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pow_dbm_q <= `RTRB_POW_MIN_DBM;
        end else begin
            pow_dbm_q <= `RTRB_POW_MIN_DBM
                + {3'h0, txpow_q[1:0]} * `RTRB_POW_STEP_DBM;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rate_hi_q <= `RTRB_RST_RATE_HI;
        end else if (wr_rate_hi) begin
            rate_hi_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rate_lo_q <= `RTRB_RST_RATE_LO;
        end else if (wr_rate_lo) begin
            rate_lo_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            scale_q <= `RTRB_RST_SCALE;
        end else if (wr_mod1) begin
            scale_q <= reg_wdata[`RTRB_BIT_SCALE];
        end
    end

    rtrb_rate_calc u_rate (
        .clk(clk),
        .srst(srst),
        .rate_word({rate_hi_q, rate_lo_q}),
        .rate_scale(scale_q),
        .rate_kbps(rate_kbps),
        .rate_low(rate_low)
    );

    // The scale choice is left to software; this only flags a slow rate
    // that is still on the fine scale.
    always_ff @(posedge clk) begin
        if (srst) begin
            low_unscaled_q <= 1'b0;
        end else begin
            low_unscaled_q <= rate_low && !scale_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            `RTRB_OFS_CONV1: rdata_d = conv1_q;
            `RTRB_OFS_CONV2: rdata_d = {3'h0, conv2_q};
            `RTRB_OFS_GAIN1: begin
                rdata_d = {2'h0, gain1_q[`RTRB_BIT_AGC_EN], gain_eff};
            end
            `RTRB_OFS_GAIN2: rdata_d = gain2_q;
            `RTRB_OFS_CIDX: rdata_d = {5'h00, cidx_q};
            `RTRB_OFS_CVAL: rdata_d = {2'h0, cif.rd_data};
            `RTRB_OFS_TXPOW: rdata_d = {4'h0, txpow_q};
            `RTRB_OFS_RATE_HI: rdata_d = rate_hi_q;
            `RTRB_OFS_RATE_LO: rdata_d = rate_lo_q;
            `RTRB_OFS_MOD1: rdata_d = {2'h0, scale_q, 5'h00};
            default: rdata_d = 8'h00;
        endcase
    end

    // Data stand only in the cycle after the strobe; zero otherwise.
    always_ff @(posedge clk) begin
        if (srst || !reg_rd) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = rdata_q;
    assign agc_enable = gain1_q[`RTRB_BIT_AGC_EN];
    assign agc_run = agc_run_q;
    assign agc_slow_rise = gain2_q[6];
    assign lna_comp = gain2_q[5:2];
    assign window_ref_adj = gain2_q[1:0];
    assign lna_gain_max = lna_max_q;
    assign lna_gain_db = lna_db_q;
    assign amp_gain_code = amp_code_q;
    assign amp_gain_db = amp_db_q;
    assign adc_reset = conv1_q[7];
    assign ref_dac_enable = conv1_q[6];
    assign adc_enable = conv1_q[5];
    assign adc_tune_override = conv1_q[4];
    assign adc_tune_value = conv1_q[3:0];
    assign vcm_enable = conv2_q[4];
    assign adc_open_loop = conv2_q[3];
    assign adc_ref_mv = ref_mv_q;
    assign filter_tap_coeff = cif.tap_data;
    assign tx_power_level = txpow_q[1:0];
    assign tx_power_extra = txpow_q[3];
    assign tx_power_dbm = pow_dbm_q;
    assign tx_rate_word = {rate_hi_q, rate_lo_q};
    assign tx_rate_scale = scale_q;
    assign tx_rate_kbps = rate_kbps;
    assign tx_rate_low_unscaled = low_unscaled_q;
endmodule

// ==== bench/rtrb_monitor.sv ====
// Concurrent checks on the ports of the radio tuning register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module rtrb_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Gain loop
    input wire logic [4:0] agc_gain_result,
    input wire logic preamble_detected,
    input wire logic agc_enable,
    input wire logic agc_run,
    input wire logic lna_gain_max,
    input wire logic [4:0] lna_gain_db,
    input wire logic [3:0] amp_gain_code,
    input wire logic [4:0] amp_gain_db,
    // Converter, taps, power and rate
    input wire logic [10:0] adc_ref_mv,
    input wire logic [2:0] filter_tap_addr,
    input wire logic [5:0] filter_tap_coeff,
    input wire logic [1:0] tx_power_level,
    input wire logic [4:0] tx_power_dbm,
    input wire logic [15:0] tx_rate_word,
    input wire logic tx_rate_scale,
    input wire logic [9:0] tx_rate_kbps
);
    // The product is kept wide so that it never wraps before the shift.
    logic [25:0] rate_full;
    logic [9:0] rate_exp;
    logic [4:0] amp_exp;
    assign rate_full = 26'h00003e8 * tx_rate_word;
    assign rate_exp = 10'(tx_rate_scale ? rate_full >> 21 : rate_full >> 16);
    assign amp_exp = (amp_gain_code > 4'h5) ? 5'h18 :
                     5'(amp_gain_code) * 5'h03;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_unmapped_read: assert property (
        reg_rd && (reg_addr < 8'h67 || reg_addr > 8'h70) |=>
        reg_rdata == 8'h00) else $error("unmapped read gave data");
    a_agc_shows_loop: assert property (
        (agc_enable && $stable(agc_gain_result))[*3] |->
        amp_gain_code == agc_gain_result[3:0] &&
        lna_gain_max == agc_gain_result[4])
        else $error("gain bits do not follow loop");
    a_lna_db_map: assert property (
        $stable(lna_gain_max)[*2] |->
        lna_gain_db == (lna_gain_max ? 5'h19 : 5'h05))
        else $error("front-end gain value wrong");
    a_amp_db_map: assert property (
        $stable(amp_gain_code)[*2] |-> amp_gain_db == amp_exp)
        else $error("amplifier gain value wrong");
    a_ref_level_map: assert property (
        (reg_wr && reg_addr == 8'h68) ##1 !(reg_wr && reg_addr == 8'h68)
        |=> adc_ref_mv == 11'h1f4 + 11'h064 * $past(reg_wdata[2:0], 2))
        else $error("reference level wrong");
    a_power_dbm_map: assert property (
        $stable(tx_power_level)[*2] |->
        tx_power_dbm == 5'h08 + 5'h03 * tx_power_level)
        else $error("power level value wrong");
    a_rate_calc: assert property (
        ($stable(tx_rate_word) && $stable(tx_rate_scale))[*3] |->
        tx_rate_kbps == rate_exp) else $error("rate value wrong");
    a_tap_none_zero: assert property (
        filter_tap_addr == 3'h7 |=> filter_tap_coeff == 6'h00)
        else $error("tap index seven not zero");
    a_agc_run_pre: assert property (
        agc_enable && preamble_detected |=> agc_run)
        else $error("gain loop not running");
endmodule

bind rtrb_bank rtrb_monitor i_rtrb_monitor (.clk, .srst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .agc_gain_result,
    .preamble_detected, .agc_enable, .agc_run, .lna_gain_max, .lna_gain_db,
    .amp_gain_code, .amp_gain_db, .adc_ref_mv, .filter_tap_addr,
    .filter_tap_coeff, .tx_power_level, .tx_power_dbm, .tx_rate_word,
    .tx_rate_scale, .tx_rate_kbps);

// ==== bench/rtrb_loop_model.sv ====
// Behavioural gain loop and preamble detector facing the bank.
// Assumes the bench sets the gain target and the preamble level.
`timescale 1ns/1ps
module rtrb_loop_model (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Bench controls
    input wire logic [4:0] gain_target,
    input wire logic preamble_in,
    // Bank side
    input wire logic agc_run,
    input wire logic agc_slow_rise,
    output logic [4:0] agc_gain_result,
    output logic preamble_detected
);
    logic rise_ok_q;
    // One step a cycle; a slow rise steps up only every other cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            agc_gain_result <= 5'h00;
            rise_ok_q <= 1'b0;
        end else if (agc_run) begin
            rise_ok_q <= ~rise_ok_q;
            if (agc_gain_result > gain_target) begin
                agc_gain_result <= agc_gain_result - 5'h01;
            end else if (agc_gain_result < gain_target &&
                         (!agc_slow_rise || rise_ok_q)) begin
                agc_gain_result <= agc_gain_result + 5'h01;
            end
        end
    end
    always_ff @(posedge clk) begin
        preamble_detected <= preamble_in & ~srst;
    end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the radio tuning register bank.
// Assumes the bank and its loop model share one 250 MHz clock.
`timescale 1ns/1ps
module tb;
    import rtrb_pkg::*;
    logic clk, srst, reg_wr, reg_rd, preamble_in, agc_enable, agc_run;
    logic agc_slow_rise, preamble_detected, lna_gain_max, adc_reset;
    logic ref_dac_enable, adc_enable, adc_tune_override, vcm_enable;
    logic adc_open_loop, tx_power_extra, tx_rate_scale, tx_rate_low_unscaled;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [4:0] agc_gain_result, gain_target, lna_gain_db, amp_gain_db;
    logic [4:0] tx_power_dbm;
    logic [3:0] lna_comp, amp_gain_code, adc_tune_value;
    logic [1:0] window_ref_adj, tx_power_level;
    logic [10:0] adc_ref_mv;
    logic [2:0] filter_tap_addr;
    logic [5:0] filter_tap_coeff;
    logic [15:0] tx_rate_word;
    logic [9:0] tx_rate_kbps;
    int err_count, num_checks, n;
    rtrb_byte_t rst_tab[10] = '{8'h1d, 8'h00, 8'h20, 8'h00, 8'h00, 8'h01,
                                8'h08, 8'h0a, 8'h0d, 8'h00};
    rtrb_byte_t wa[9] = '{8'h67, 8'h68, 8'h6a, 8'h6b, 8'h6d, 8'h6e, 8'h70,
                          8'h66, 8'h71};
    rtrb_byte_t we[9] = '{8'hfb, 8'h1b, 8'hfb, 8'h03, 8'h0b, 8'hfb, 8'h20,
                          8'h00, 8'h00};
    rtrb_coeff_t coef[7] = '{6'h01, 6'h03, 6'h06, 6'h0a, 6'h0f, 6'h13, 6'h14};
    logic [16:0] rcase[3] = '{{16'h0a0d, 1'b0}, {16'h0400, 1'b0},
                              {16'hf000, 1'b1}};

    rtrb_bank i_rtrb_bank (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .agc_gain_result, .preamble_detected,
        .agc_enable, .agc_run, .agc_slow_rise, .lna_comp, .window_ref_adj,
        .lna_gain_max, .lna_gain_db, .amp_gain_code, .amp_gain_db,
        .adc_reset, .ref_dac_enable, .adc_enable, .adc_tune_override,
        .adc_tune_value, .vcm_enable, .adc_open_loop, .adc_ref_mv,
        .filter_tap_addr, .filter_tap_coeff, .tx_power_level,
        .tx_power_extra, .tx_power_dbm, .tx_rate_word, .tx_rate_scale,
        .tx_rate_kbps, .tx_rate_low_unscaled);
    rtrb_loop_model i_rtrb_loop_model (.clk, .srst, .gain_target,
        .preamble_in, .agc_run, .agc_slow_rise, .agc_gain_result,
        .preamble_detected);

    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic wr(input rtrb_byte_t a, input rtrb_byte_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input rtrb_byte_t a, input rtrb_byte_t exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk_val(16'(reg_rdata), 16'(exp));
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        gain_target = 5'h00;
        preamble_in = 1'b0;
        filter_tap_addr = 3'h0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd_chk(8'h67 + 8'(i), rst_tab[i]);
        end
        for (int i = 0; i < 9; i++) begin
            wr(wa[i], 8'hfb);
            rd_chk(wa[i], we[i]);
        end
        chk_val({adc_reset, ref_dac_enable, adc_enable,
            adc_tune_override, adc_tune_value, vcm_enable, adc_open_loop,
            tx_rate_scale}, 16'h07df);
        for (int c = 0; c < 8; c++) begin
            wr(8'h68, 8'(c));
            settle();
            chk_val(16'(adc_ref_mv), 16'(500 + 100 * c));
        end
        for (int i = 0; i < 7; i++) begin
            wr(8'h6b, 8'(i));
            rd_chk(8'h6c, {2'b00, coef[i]});
            filter_tap_addr <= 3'(i);
            settle();
            chk_val(16'(filter_tap_coeff), 16'(coef[i]));
        end
        wr(8'h6b, 8'h03);
        wr(8'h6c, 8'hff);
        rd_chk(8'h6c, 8'h3f);
        filter_tap_addr <= 3'h3;
        settle();
        chk_val(16'(filter_tap_coeff), 16'h003f);
        wr(8'h6b, 8'h07);
        rd_chk(8'h6c, 8'h00);
        wr(8'h6c, 8'h2a);
        wr(8'h6b, 8'h06);
        rd_chk(8'h6c, 8'h14);
        filter_tap_addr <= 3'h7;
        wr(8'h6a, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(8'h69, {3'b000, 1'(c), 4'(c)});
            settle();
            chk_val(16'(amp_gain_db), 16'((c > 5) ? 24 : 3 * c));
            chk_val(16'(lna_gain_db), (c % 2) ? 16'h19 : 16'h05);
            rd_chk(8'h69, {3'b000, 1'(c), 4'(c)});
        end
        gain_target <= 5'h13;
        preamble_in <= 1'b1;
        wr(8'h69, 8'h20);
        n = 0;
        while (agc_gain_result !== 5'h13 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n == 200) begin
            err_count++;
            print_verdict();
        end
        settle();
        rd_chk(8'h69, 8'h33);
        chk_val(16'(amp_gain_code), 16'h0003);
        chk_val(16'(lna_gain_db), 16'h19);
        preamble_in <= 1'b0;
        wr(8'h6a, 8'h6b);
        settle();
        chk_val({agc_slow_rise, lna_comp, window_ref_adj}, 16'h6b);
        chk_val(16'(agc_run), 16'h0000);
        wr(8'h6a, 8'h80);
        settle();
        chk_val(16'(agc_run), 16'h0001);
        for (int l = 0; l < 4; l++) begin
            wr(8'h6d, 8'(l) | ((l % 2) ? 8'h08 : 8'h00));
            settle();
            chk_val(16'(tx_power_dbm), 16'(8 + 3 * l));
            chk_val(16'(tx_power_extra), 16'(l % 2));
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'h6e, rcase[i][16:9]);
            wr(8'h6f, rcase[i][8:1]);
            wr(8'h70, {2'b00, rcase[i][0], 5'b00000});
            settle();
            chk_val(tx_rate_word, rcase[i][16:1]);
            chk_val(16'(tx_rate_kbps),
                16'((26'h3e8 * rcase[i][16:1]) >> (rcase[i][0] ? 21 : 16)));
            chk_val(16'(tx_rate_low_unscaled), 16'(i == 1));
        end
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd_chk(8'h67, 8'h1d);
        print_verdict();
    end
endmodule
